// ---- bench/epwi_pads_model.sv ----
// Purpose: External circuitry on the eight pads.
// Assumes: The bench says which pins are driven from outside.
// Notes:   Undriven, unpulled pins wander every cycle.
`timescale 1ns/1ps
`default_nettype none
module epwi_pads_model
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] padPullup,
  input  wire logic [7:0] extDrive,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] padIn
);
  logic [7:0] floatLvl_r = 8'h5A; // A floating pad never holds its level.
  always_ff @(posedge sys_clk)
  begin
    floatLvl_r <= ~floatLvl_r;
  end
  // Our driver first, then the outside, then the pull-up.
  always_comb
  begin
    padIn = (padOe & padOut) | (~padOe & extDrive & extLevel)
          | (~padOe & ~extDrive & padPullup)
          | (~padOe & ~extDrive & ~padPullup & floatLvl_r);
  end
endmodule : epwi_pads_model
`default_nettype wire

// ---- bench/epwi_port_chk.sv ----
// Purpose: Port-level checks of the eight-pin port.
// Assumes: Sees only the top module's ports.
// Notes:   Bound to the port below.
`timescale 1ns/1ps
`default_nettype none
module epwi_port_chk
  import epwi_pkg::*;
#(
  parameter int ADDR_W = 20
)
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [31:0]       regRdata,
  input wire logic [7:0]        padIn,
  input wire logic [7:0]        padOut,
  input wire logic [7:0]        padOe,
  input wire logic [7:0]        padPullup,
  input wire logic [7:0]        padInputEn
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Only bits whose mask is 1 take the new value.
  function automatic logic [7:0] upd(logic [7:0] o, logic [7:0] d,
                                     logic [7:0] m);
    return (o & ~m) | (d & m);
  endfunction : upd
  wire wr0 = regWrite && regAddr == ADDR_PULL_DRIVE;
  property p_oe_wr;
    wr0 |=> padOe == upd($past(padOe), $past(regWdata[7:0]),
                         $past(regWdata[15:8]));
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("oe write");
  property p_pu_wr;
    wr0 |=> padPullup == upd($past(padPullup), $past(regWdata[23:16]),
                             $past(regWdata[31:24]));
  endproperty
  a_pu_wr: assert property (p_pu_wr) else $error("pu write");
  property p_ie_wr;
    regWrite && regAddr == ADDR_INEN_OUTVAL |=> padInputEn == upd(
      $past(padInputEn), $past(regWdata[23:16]), $past(regWdata[31:24]));
  endproperty
  a_ie_wr: assert property (p_ie_wr) else $error("ie write");
  property p_drive;
    (padOut & ~padOe) == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("undriven pin");
  property p_pad_rd;
    regRead && regAddr == ADDR_PAD_LEVEL && $stable(padIn) |=>
      regRdata == {24'h00_0000, $past(padIn)};
  endproperty
  a_pad_rd: assert property (p_pad_rd) else $error("pad read");
  property p_dir_rd;
    regRead && regAddr == ADDR_PULL_DRIVE |=>
      regRdata == {8'h00, $past(padPullup), 8'h00, $past(padOe)};
  endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("reg0 read");
  property p_rst;
    $rose(rst_n) |-> {padOe, padPullup, padInputEn, padOut} == 32'h0000_0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_rd_idle;
    !$past(regRead) |-> regRdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle data");
endmodule : epwi_port_chk
bind epwi_port epwi_port_chk #(.ADDR_W(ADDR_W)) epwi_port_chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .padIn(padIn), .padOut(padOut), .padOe(padOe),
  .padPullup(padPullup), .padInputEn(padInputEn));
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Self-checking bench of the eight-pin port.
// Assumes: One 100 MHz clock and a strobe register port.
// Notes:   Pads come from the pad model.
`timescale 1ns/1ps
`default_nettype none
module tb
  import epwi_pkg::*;
;
  logic        sys_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic [19:0] regAddr  = 20'h0_0000;
  logic [31:0] regWdata = 32'h0000_0000;
  logic        regWrite = 1'b0;
  logic        regRead  = 1'b0;
  logic [7:0]  extDrive = 8'h00;
  logic [7:0]  extLevel = 8'h00;
  logic [31:0] regRdata;
  logic [31:0] rdVal;
  logic [7:0]  padIn, padOut, padOe, padPullup, padInputEn;
  logic        irq;
  logic        wakeBit;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  epwi_port epwi_port_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .padInputEn(padInputEn), .irq(irq));
  epwi_pads_model epwi_pads_model_inst (.sys_clk(sys_clk),
    .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .extDrive(extDrive), .extLevel(extLevel), .padIn(padIn));
  always #5 sys_clk = ~sys_clk;
  // A hang is cut short after far more cycles than the run needs.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [19:0] a);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    rdVal = regRdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic rdc(input logic [19:0] a, input logic [31:0] e, string n);
    rd(a);
    chk(n, e, rdVal);
  endtask : rdc
  task automatic t_reset();
    rdc(ADDR_INEN_OUTVAL, 32'h0000_0000, "reg1");
    rdc(ADDR_TRIG_WAKE, 32'h0000_0000, "reg3");
    rdc(20'h4_0820, 32'h0000_0000, "unmapped");
  endtask : t_reset
  task automatic t_drive();
    wr(ADDR_PULL_DRIVE, 32'h0000_FFAA);
    wr(ADDR_INEN_OUTVAL, 32'h0000_FF5A);
    chk("padOut", 32'h0000_000A, {24'h00_0000, padOut});
    wr(ADDR_PULL_DRIVE, 32'hFF55_0F00);
    rdc(ADDR_PULL_DRIVE, 32'h0055_00A0, "reg0");
  endtask : t_drive
  task automatic t_input();
    wr(ADDR_PULL_DRIVE, 32'hFFFF_FF00);
    wr(ADDR_INEN_OUTVAL, 32'hFFFF_0000);
    extDrive <= 8'h0F;
    extLevel <= 8'h05;
    rdc(ADDR_INEN_OUTVAL, 32'h00FF_005A, "reg1");
    wr(ADDR_PAD_LEVEL, 32'hFFFF_FFFF);
    rdc(ADDR_PAD_LEVEL, 32'h0000_00F5, "pads");
    // Pin 0 turns analog: its pull-up and input path are both left off.
    wr(ADDR_PULL_DRIVE, 32'h0100_0000);
    wr(ADDR_INEN_OUTVAL, 32'h0100_0000);
    rdc(ADDR_PULL_DRIVE, 32'h00FE_0000, "analog reg0");
    rdc(ADDR_INEN_OUTVAL, 32'h00FE_005A, "analog reg1");
  endtask : t_input
  task automatic t_wake();
    extDrive <= 8'hFF;
    extLevel <= 8'h00;
    wr(ADDR_TRIG_WAKE, 32'hFFFA_C688);
    rd(ADDR_TRIG_WAKE);
    chk("wake low", 32'hA2FA_C688, rdVal & 32'hF7FF_FFFF);
    wakeBit = rdVal[27];
    extLevel <= 8'hFF;
    // The change state flips one cycle after the sampled level moves.
    repeat (2) @(posedge sys_clk);
    rd(ADDR_TRIG_WAKE);
    chk("wake high", 32'h54FA_C688, rdVal & 32'hF7FF_FFFF);
    chk("toggle", {31'h0000_0000, ~wakeBit}, {31'h0000_0000, rdVal[27]});
  endtask : t_wake
  task automatic t_irq();
    wr(ADDR_TRIG_WAKE, 32'h0000_0008);
    extLevel <= 8'h00;
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    wr(ADDR_GLOBAL_EN, 32'h0000_0001);
    rd(ADDR_IRQ_STATUS);
    chk("irq idle", 32'h0000_0000, {31'h0000_0000, irq});
    extLevel <= 8'h02;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("irq rise", 32'h0000_0001, {31'h0000_0000, irq});
    wr(ADDR_GLOBAL_EN, 32'h0000_0000);
    chk("irq global", 32'h0000_0000, {31'h0000_0000, irq});
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    wr(ADDR_GLOBAL_EN, 32'h0000_0001);
    chk("irq mask", 32'h0000_0000, {31'h0000_0000, irq});
    rdc(ADDR_IRQ_STATUS, 32'h0000_0002, "status");
    rdc(ADDR_IRQ_STATUS, 32'h0000_0000, "cleared");
  endtask : t_irq
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_drive();
    t_input();
    t_wake();
    t_irq();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// ---- design/epwi_detect.sv ----
// Purpose: Per-pin trigger detection and wake-condition flags.
// Assumes: Pad levels already sampled in the system clock domain.
// Notes:   Level triggers fire every cycle the level holds.
`timescale 1ns/1ps
`default_nettype none
module epwi_detect
  import epwi_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  epwi_detect_if.det       dio
);
  logic [7:0] prevLevel_r;  // Pad level one cycle earlier.
  logic [7:0] chgState_r;   // Toggles on every pad change.
  logic [7:0] evt;          // Combined event vector.
  logic [7:0] wake;         // Combined wake vector.

  // Previous level, used for edge detection.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      prevLevel_r <= BYTE_RESET;
    else
      prevLevel_r <= dio.padLevel;

  // Change-trigger state flips on each edge, so its wake flag tracks it.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      chgState_r <= BYTE_RESET;
    else
      chgState_r <= chgState_r ^ (prevLevel_r ^ dio.padLevel);

  // Decode each pin's code into an event and a wake flag.
  always_comb
  begin
    evt  = 8'h00;
    wake = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      unique case (epwi_trig_t'(dio.trigSel[i*TRIG_WIDTH +: TRIG_WIDTH]))
        EPWI_TRIG_OFF:
        begin
          evt[i]  = 1'b0;
          wake[i] = 1'b0;                                  // [R14]
        end
        EPWI_TRIG_RISE:
        begin
          evt[i]  = dio.padLevel[i] & ~prevLevel_r[i];     // [R11]
          wake[i] = ~dio.padLevel[i];                      // [R14]
        end
        EPWI_TRIG_FALL:
        begin
          evt[i]  = ~dio.padLevel[i] & prevLevel_r[i];     // [R11]
          wake[i] = dio.padLevel[i];                       // [R14]
        end
        EPWI_TRIG_CHG:
        begin
          evt[i]  = dio.padLevel[i] ^ prevLevel_r[i];      // [R11]
          wake[i] = chgState_r[i];                         // [R14]
        end
        EPWI_TRIG_LOW, EPWI_TRIG_LOW2:
        begin
          evt[i]  = ~dio.padLevel[i];                      // [R11]
          wake[i] = dio.padLevel[i];                       // [R14]
        end
        EPWI_TRIG_HIGH, EPWI_TRIG_HIGH2:
        begin
          evt[i]  = dio.padLevel[i];                       // [R11]
          wake[i] = ~dio.padLevel[i];                      // [R14]
        end
      endcase
    end
  end

  assign dio.event_   = evt;
  assign dio.wakeFlag = wake;
endmodule : epwi_detect
`default_nettype wire

// ---- design/epwi_detect_if.sv ----
// Purpose: Carries pad levels and trigger codes into the detector.
// Assumes: Eight pins.
// Notes:   Detector drives events and wake flags back.
`timescale 1ns/1ps
`default_nettype none
interface epwi_detect_if;
  logic [7:0]  padLevel;   // Sampled pad levels.
  logic [23:0] trigSel;    // Packed trigger codes.
  logic [7:0]  event_;     // Trigger events; edge codes pulse one cycle, level codes hold.
  logic [7:0]  wakeFlag;   // Wake-condition flags.
  modport ctrl (output padLevel, output trigSel,
                input event_, input wakeFlag);
  modport det  (input padLevel, input trigSel,
                output event_, output wakeFlag);
endinterface : epwi_detect_if
`default_nettype wire

// ---- design/epwi_pkg.sv ----
// Purpose: Shared constants for the eight-pin port with wake and interrupt.
// Assumes: 32-bit register port, word-aligned byte addresses.
// Notes:   Offsets are the printed byte addresses of the register bank.
package epwi_pkg;
  // Register byte addresses.
  localparam logic [19:0] ADDR_PULL_DRIVE  = 20'h4_0800;
  localparam logic [19:0] ADDR_INEN_OUTVAL = 20'h4_0804;
  localparam logic [19:0] ADDR_PAD_LEVEL   = 20'h4_0808;
  localparam logic [19:0] ADDR_TRIG_WAKE   = 20'h4_080C;
  localparam logic [19:0] ADDR_IRQ_STATUS  = 20'h4_0810;
  localparam logic [19:0] ADDR_IRQ_MASK    = 20'h4_0814;
  localparam logic [19:0] ADDR_GLOBAL_EN   = 20'h4_0818;
  // Field positions (low bit of each byte field) and trigger code width.
  localparam int LO_FIELD_POS   = 0;
  localparam int LO_MASK_POS    = 8;
  localparam int HI_FIELD_POS   = 16;
  localparam int HI_MASK_POS    = 24;
  localparam int WAKE_POS       = 24;
  localparam int TRIG_WIDTH     = 3;
  // Reset values.
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [23:0] TRIG_RESET = 24'h00_0000;
  // Trigger codes.
  typedef enum logic [2:0] {
    EPWI_TRIG_OFF   = 3'h0,
    EPWI_TRIG_RISE  = 3'h1,
    EPWI_TRIG_FALL  = 3'h2,
    EPWI_TRIG_CHG   = 3'h3,
    EPWI_TRIG_LOW   = 3'h4,
    EPWI_TRIG_HIGH  = 3'h5,
    EPWI_TRIG_LOW2  = 3'h6,
    EPWI_TRIG_HIGH2 = 3'h7
  } epwi_trig_t;
endpackage : epwi_pkg

// ---- design/epwi_port.sv ----
// Purpose: Eight-pin general-purpose port with wake flags and interrupt.
// Assumes: Pads synchronous to sys_clk; simple strobe register port.
// Notes:   Mask bytes gate writes bit by bit and always read as zero.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Pull-up enables in first register 23:16.
// (R2) Drive enables in first register 7:0.
// (R3) Enabled pins drive output value bits.
// (R4) Input enables in second register 23:16.
// (R5) Pad levels read in third register.
// (R6) Software never enables input and output together.
// (R7) Software pulls up floating input pins.
// (R8) Output pins keep pull-up and input off.
// (R9) Analog pins may leave input and pull-up off.
// (R10) Interrupt pins need input mode and pull-up.
// (R11) Three-bit trigger selector per pin.
// (R12) Trigger sets flag; enables gate interrupt.
// (R13) Read-only wake flags in bits 31:24.
// (R14) Wake flag follows trigger code.
// (R15) Mask bytes are bitwise write enables.
// (R16) Masks read zero; everything resets to zero.
module epwi_port
  import epwi_pkg::*;
#(
  parameter int ADDR_W = 20
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdata,
  input  wire logic [7:0]        padIn,
  output logic      [7:0]        padOut,
  output logic      [7:0]        padOe,
  output logic      [7:0]        padPullup,
  output logic      [7:0]        padInputEn,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [7:0]  pullEn_r;     // Per-pin pull-up enable.
  logic [7:0]  driveEn_r;    // Per-pin output drive enable.
  logic [7:0]  outVal_r;     // Per-pin output value.
  logic [7:0]  inEn_r;       // Per-pin input buffer enable.
  logic [23:0] trigSel_r;    // Packed trigger selectors.
  logic [7:0]  padLevel_r;   // Sampled pad level.
  logic [7:0]  irqStat_r;    // Sticky per-pin interrupt flags.
  logic [7:0]  irqMask_r;    // Per-pin interrupt enable.
  logic        globalEn_r;   // Global interrupt enable.
  logic [7:0]  statClr;      // Status bits cleared by this read.

  epwi_detect_if dio ();

  // Merge a write byte into a field under its mask byte.
  function automatic logic [7:0] maskedMerge(input logic [7:0] cur,
                                             input logic [7:0] dat,
                                             input logic [7:0] msk);
    maskedMerge = (cur & ~msk) | (dat & msk);
  endfunction : maskedMerge

  // Decode one address against the register port.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [19:0] base);
    hit = (a == base[ADDR_W-1:0]);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // Pad sampling; the pad is taken as synchronous to the clock.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      padLevel_r <= BYTE_RESET;
    else
      padLevel_r <= padIn;                                 // [R5]

  ////////////////////////////////////////////////////////////////////////
  // First control register: pull-up and drive enables.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      pullEn_r  <= BYTE_RESET;                             // [R16]
      driveEn_r <= BYTE_RESET;                             // [R16]
    end
    else if (regWrite && hit(regAddr, ADDR_PULL_DRIVE))
    begin
      // Mask bytes select which bits the write touches.
      pullEn_r  <= maskedMerge(pullEn_r,
                     regWdata[HI_FIELD_POS +: 8],
                     regWdata[HI_MASK_POS +: 8]);          // [R1] [R15]
      driveEn_r <= maskedMerge(driveEn_r,
                     regWdata[LO_FIELD_POS +: 8],
                     regWdata[LO_MASK_POS +: 8]);          // [R2] [R15]
    end

  // Second control register: input enables and output values.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      inEn_r   <= BYTE_RESET;                              // [R16]
      outVal_r <= BYTE_RESET;                              // [R16]
    end
    else if (regWrite && hit(regAddr, ADDR_INEN_OUTVAL))
    begin
      inEn_r   <= maskedMerge(inEn_r,
                    regWdata[HI_FIELD_POS +: 8],
                    regWdata[HI_MASK_POS +: 8]);           // [R4] [R15]
      outVal_r <= maskedMerge(outVal_r,
                    regWdata[LO_FIELD_POS +: 8],
                    regWdata[LO_MASK_POS +: 8]);           // [R3] [R15]
    end

  // Trigger selectors; the wake byte above them is read-only.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      trigSel_r <= TRIG_RESET;                             // [R16]
    else if (regWrite && hit(regAddr, ADDR_TRIG_WAKE))
      trigSel_r <= regWdata[23:0];                         // [R11]

  // Interrupt mask and global enable.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      irqMask_r  <= BYTE_RESET;                            // [R16]
      globalEn_r <= 1'b0;                                  // [R16]
    end
    else
    begin
      if (regWrite && hit(regAddr, ADDR_IRQ_MASK))
        irqMask_r <= regWdata[7:0];
      if (regWrite && hit(regAddr, ADDR_GLOBAL_EN))
        globalEn_r <= regWdata[0];
    end

  ////////////////////////////////////////////////////////////////////////
  // Trigger detection and wake flags.
  assign dio.padLevel = padLevel_r;
  assign dio.trigSel  = trigSel_r;

  epwi_detect u_detect (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .dio     (dio)
  );

  // A read of the status register clears what it returned.
  assign statClr = (regRead && hit(regAddr, ADDR_IRQ_STATUS))
                   ? irqStat_r : 8'h00;

  // Sticky flags: a new event in the clearing cycle survives the clear.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      irqStat_r <= BYTE_RESET;
    else
      irqStat_r <= (irqStat_r & ~statClr) | dio.event_;   // [R12]

  // Interrupt only when pin enable and global enable are both set.
  assign irq = globalEn_r && |(irqStat_r & irqMask_r);     // [R12]

  ////////////////////////////////////////////////////////////////////////
  // Pad controls follow the registers; padOut is the output value gated by the drive enables.
  assign padOe      = driveEn_r;                           // [R2]
  assign padOut     = outVal_r & driveEn_r;                // [R3]
  assign padPullup  = pullEn_r;                            // [R1]
  assign padInputEn = inEn_r;                              // [R4]

  ////////////////////////////////////////////////////////////////////////
  // Read data: registered, valid the cycle after the strobe only.
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      regRdata <= 32'h0000_0000;
    else if (!regRead)
      regRdata <= 32'h0000_0000;
    else if (hit(regAddr, ADDR_PULL_DRIVE))
      regRdata <= {8'h00, pullEn_r, 8'h00, driveEn_r};     // [R16]
    else if (hit(regAddr, ADDR_INEN_OUTVAL))
      regRdata <= {8'h00, inEn_r, 8'h00, outVal_r};        // [R16]
    else if (hit(regAddr, ADDR_PAD_LEVEL))
      regRdata <= {24'h00_0000, padLevel_r};               // [R5]
    else if (hit(regAddr, ADDR_TRIG_WAKE))
      regRdata <= {dio.wakeFlag, trigSel_r};               // [R13]
    else if (hit(regAddr, ADDR_IRQ_STATUS))
      regRdata <= {24'h00_0000, irqStat_r};
    else if (hit(regAddr, ADDR_IRQ_MASK))
      regRdata <= {24'h00_0000, irqMask_r};
    else if (hit(regAddr, ADDR_GLOBAL_EN))
      regRdata <= {31'h0000_0000, globalEn_r};
    else
      regRdata <= 32'h0000_0000;  // Unmapped reads return zero.
endmodule : epwi_port
`default_nettype wire
